// >>> wru_pkg.sv
// Purpose: shared constants and types of the watchdog and reset unit
// Assumes: 10 MHz system clock, 8-bit register port
// Notes: times are kept in their own unit, counts derived below

package wru_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] WRU_CLEAR_OFS = 8'ha6;
   localparam logic [7:0] WRU_STATUS_OFS = 8'ha7;
   localparam logic [7:0] WRU_KEY_OFS = 8'hae;
   localparam logic [7:0] WRU_KEY_RST = 8'h00;
   localparam logic [7:0] WRU_KEY_OFF = 8'h55;
   localparam logic [7:0] WRU_CLR_FIRST = 8'h1e;
   localparam logic [7:0] WRU_CLR_SECOND = 8'he1;
   localparam logic [7:0] WRU_RDATA_NONE = 8'h00;

   // status fields
   localparam int WRU_ST_ENABLED = 0;
   localparam int WRU_ST_ARMED = 1;
   localparam int WRU_ST_WD_CAUSE = 2;
   localparam int WRU_ST_LV_CAUSE = 3;
   localparam int WRU_ST_EXT_CAUSE = 4;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int WRU_CLK_KHZ = 10000;
   localparam int WRU_MC_CLOCKS = 12;
   localparam int WRU_WD_WIDTH = 19;
   localparam int WRU_WD_LIMIT = 524288;
   localparam int WRU_WD_PULSE_MC = 2048;
   // strictly more than the documented machine-cycle count
   localparam int WRU_WD_PULSE_CYCLES = (WRU_WD_PULSE_MC + 1) * WRU_MC_CLOCKS;
   localparam int WRU_LV_HOLD_US = 2000;
   localparam int WRU_LV_HOLD_CYCLES = (WRU_LV_HOLD_US * WRU_CLK_KHZ + 999)
                                       / 1000;
   localparam int WRU_PULSE_W = 16;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wru_req_s;

   typedef enum logic [1:0] {
      WRU_IDLE,
      WRU_ARMED
   } wru_clr_e;

endpackage

// >>> wru_sync.sv
// Purpose: two-flop synchroniser for one pin level
// Assumes: input is asynchronous to sys_clk
// Notes: reset value is a parameter so a pin can idle high

`timescale 1ns/1ps
`default_nettype none

module wru_sync #(
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // level
   input wire logic din,
   output logic dout
);

   logic meta_reg;
   logic meta_next;
   logic dout_next;

   assign meta_next = din;
   assign dout_next = meta_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_reg <= INIT;
         dout <= INIT;
      end else begin
         meta_reg <= meta_next;
         dout <= dout_next;
      end
   end

endmodule

`default_nettype wire

// >>> wru_mc_div.sv
// Purpose: machine-cycle enable, one pulse every twelve clocks
// Assumes: single clock domain
// Notes: only rst restarts the phase

`timescale 1ns/1ps
`default_nettype none

module wru_mc_div
   import wru_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // enable pulse
   output logic tick
);

   localparam logic [3:0] LAST = 4'(WRU_MC_CLOCKS - 1);

   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   wire at_last;

   assign at_last = (cnt_reg == LAST);
   assign cnt_next = at_last ? 4'h0 : cnt_reg + 4'h1;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_reg <= 4'h0;
         tick <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick <= at_last;
      end
   end

endmodule

`default_nettype wire

// >>> wru_top.sv
// Purpose: watchdog counter and merge of three reset causes
// Assumes: 10 MHz sys_clk, register port answers one cycle later
// Notes: long counts are parameters so simulation can shorten them

`timescale 1ns/1ps
`default_nettype none

// Function
// RL1 - external pin, watchdog overflow or low supply each raise internal reset
// RL2 - internal reset forces the block's registers to reset values
// RL3 - outside circuit holds reset pin low for at least 24 clocks
// RL4 - watchdog overflow gives reset pulse longer than 2048 machine cycles
// RL5 - reset held 2 ms more after supply rises above threshold
// RL6 - watchdog is a 19-bit up-counter, not readable nor writable
// RL7 - enabled counter advances once per machine cycle
// RL8 - counter overflows at 524288 and triggers a reset
// RL9 - watchdog enabled automatically, no software setup
// RL10 - watchdog and reset logic keep running in idle
// RL11 - counter clears only after writes 1e then e1 to clear register
// RL12 - software refreshes at least every 524288 machine cycles
// RL13 - clear register write-only, count never readable
// RL14 - key value 55 alone disables the watchdog
// RL15 - key register resets to zero, so watchdog enabled after reset
// RL16 - machine cycle is twelve clocks, the watchdog count rate
// RL17 - long idle software should wake periodically to refresh
// RL18 - 1e arms, e1 then clears, any other value disarms
// RL19 - internal reset is OR of synced pin, watchdog pulse, low supply
module wru_top
   import wru_pkg::*;
#(
   parameter int WD_LIMIT = WRU_WD_LIMIT,
   parameter int WD_PULSE_CYCLES = WRU_WD_PULSE_CYCLES,
   parameter int LV_HOLD_CYCLES = WRU_LV_HOLD_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // reset sources
   input wire logic ext_reset_n,
   input wire logic supply_low,
   // register port
   input wire wru_req_s reg_req,
   output logic [7:0] reg_rdata,
   // reset output and state
   output logic internal_reset,
   output logic watchdog_enabled
);

   localparam logic [WRU_WD_WIDTH-1:0] WD_LAST =
      WRU_WD_WIDTH'(WD_LIMIT - 1);
   localparam logic [WRU_PULSE_W-1:0] WD_PULSE_LOAD =
      WRU_PULSE_W'(WD_PULSE_CYCLES);
   localparam logic [WRU_PULSE_W-1:0] LV_LOAD = WRU_PULSE_W'(LV_HOLD_CYCLES);
   localparam logic [WRU_PULSE_W-1:0] PULSE_ZERO = '0;
   localparam logic [WRU_PULSE_W-1:0] PULSE_ONE = WRU_PULSE_W'(1);

   // ------------------------------------------------------------------
   // synchronisers and machine-cycle enable
   // ------------------------------------------------------------------
   logic ext_n_s;
   logic lv_s;
   logic mc_tick;

   wru_sync #(.INIT(1'b1)) u_ext_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .din(ext_reset_n),
      .dout(ext_n_s)
   );

   wru_sync #(.INIT(1'b1)) u_lv_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .din(supply_low),
      .dout(lv_s)
   );

   // idle gates nothing here, so the watchdog keeps counting in idle
   wru_mc_div u_mc_div ( // RL16 RL10
      .sys_clk(sys_clk),
      .rst(rst),
      .tick(mc_tick)
   );

   // ------------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------------
   logic [7:0] key_reg;
   logic [7:0] key_next;
   wru_clr_e clr_reg;
   wru_clr_e clr_next;
   logic [4:0] cause_reg;
   logic [4:0] cause_next;
   logic [WRU_WD_WIDTH-1:0] wd_reg;
   logic [WRU_WD_WIDTH-1:0] wd_next;
   logic [WRU_PULSE_W-1:0] wdp_reg;
   logic [WRU_PULSE_W-1:0] wdp_next;
   logic [WRU_PULSE_W-1:0] lvc_reg;
   logic [WRU_PULSE_W-1:0] lvc_next;
   logic [7:0] rdata_next;

   wire blk_rst = rst | internal_reset; // RL2
   wire wr_clear = reg_req.wr & (reg_req.addr == WRU_CLEAR_OFS);
   wire wr_key = reg_req.wr & (reg_req.addr == WRU_KEY_OFS);
   wire wr_status = reg_req.wr & (reg_req.addr == WRU_STATUS_OFS);
   wire wd_en = (key_reg != WRU_KEY_OFF); // RL14 RL9
   wire clear_hit = wr_clear & (clr_reg == WRU_ARMED)
                    & (reg_req.wdata == WRU_CLR_SECOND); // RL11
   wire wd_step = wd_en & mc_tick & ~internal_reset; // RL7
   wire wd_over = wd_step & (wd_reg == WD_LAST) & ~clear_hit; // RL8
   wire wdp_act = (wdp_reg != PULSE_ZERO);
   wire lv_act = lv_s | (lvc_reg != PULSE_ZERO);
   wire [7:0] status_val = {3'h0, cause_reg[4:2], clr_reg == WRU_ARMED,
                            wd_en};

   // the watchdog count has no read path at all
   assign rdata_next = !reg_req.rd ? WRU_RDATA_NONE : // RL13 RL6
                       (reg_req.addr == WRU_KEY_OFS) ? key_reg :
                       (reg_req.addr == WRU_STATUS_OFS) ? status_val :
                       WRU_RDATA_NONE;

   assign key_next = wr_key ? reg_req.wdata : key_reg;

   // ------------------------------------------------------------------
   // refresh sequence
   // ------------------------------------------------------------------
   always_comb begin
      clr_next = clr_reg;
      if (wr_clear) begin
         case (clr_reg)
            WRU_IDLE: begin
               clr_next = (reg_req.wdata == WRU_CLR_FIRST) ? WRU_ARMED
                                                           : WRU_IDLE; // RL18
            end
            WRU_ARMED: begin
               // a repeated 1e keeps the sequence armed
               clr_next = (reg_req.wdata == WRU_CLR_FIRST) ? WRU_ARMED
                                                           : WRU_IDLE; // RL18
            end
            default: begin
               clr_next = WRU_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // watchdog counter and reset pulse timers
   // ------------------------------------------------------------------
   assign wd_next = (clear_hit | wd_over) ? '0 : // RL11 RL8
                    wd_step ? wd_reg + 1'b1 : wd_reg; // RL7 RL6

   // pulse and hold timers answer only to rst, else they cut themselves
   assign wdp_next = wd_over ? WD_PULSE_LOAD : // RL4
                     wdp_act ? wdp_reg - PULSE_ONE : wdp_reg;
   assign lvc_next = lv_s ? LV_LOAD : // RL5
                     (lvc_reg != PULSE_ZERO) ? lvc_reg - PULSE_ONE : lvc_reg;

   // cause flags: set wins over a software clear in the same cycle
   wire [4:0] cause_set = {~ext_n_s, lv_s, wd_over, 2'b00};
   wire [4:0] cause_clr = wr_status ? reg_req.wdata[4:0] : 5'h00;
   assign cause_next = (cause_reg & ~cause_clr) | cause_set;

   always_ff @(posedge sys_clk) begin
      if (blk_rst) begin
         key_reg <= WRU_KEY_RST; // RL15
         clr_reg <= WRU_IDLE;
         wd_reg <= '0;
      end else begin
         key_reg <= key_next;
         clr_reg <= clr_next;
         wd_reg <= wd_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wdp_reg <= PULSE_ZERO;
         lvc_reg <= PULSE_ZERO;
         cause_reg <= 5'h00;
         internal_reset <= 1'b1;
         reg_rdata <= WRU_RDATA_NONE;
         watchdog_enabled <= 1'b1;
      end else begin
         wdp_reg <= wdp_next;
         lvc_reg <= lvc_next;
         cause_reg <= cause_next;
         internal_reset <= ~ext_n_s | wdp_act | lv_act; // RL1 RL19 RL3
         reg_rdata <= rdata_next;
         watchdog_enabled <= wd_en;
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   property p_ext_reset;
      @(posedge sys_clk) disable iff (rst)
      !ext_n_s |=> internal_reset;
   endproperty
   a_ext_reset: assert property (p_ext_reset) // RL1
      else $error("pin reset did not raise internal reset");

   property p_or_merge;
      @(posedge sys_clk) disable iff (rst)
      (ext_n_s && !wdp_act && !lv_act) |=> !internal_reset;
   endproperty
   a_or_merge: assert property (p_or_merge) // RL19
      else $error("internal reset without any cause");

   property p_key_cleared;
      @(posedge sys_clk) disable iff (rst)
      internal_reset |=> (key_reg == WRU_KEY_RST) && wd_reg == '0;
   endproperty
   a_key_cleared: assert property (p_key_cleared) // RL2
      else $error("registers not reset by internal reset");

   property p_wd_pulse;
      @(posedge sys_clk) disable iff (rst)
      wd_over |=> wdp_reg == WD_PULSE_LOAD ##1 internal_reset[*8];
   endproperty
   a_wd_pulse: assert property (p_wd_pulse) // RL4
      else $error("watchdog pulse wrong length");

   property p_lv_hold;
      @(posedge sys_clk) disable iff (rst)
      $fell(lv_s) |-> lvc_reg == LV_LOAD ##1 internal_reset[*8];
   endproperty
   a_lv_hold: assert property (p_lv_hold) // RL5
      else $error("low supply hold not started");

   property p_count_step;
      @(posedge sys_clk) disable iff (rst)
      (wd_step && !clear_hit && wd_reg != WD_LAST && !blk_rst)
         |=> wd_reg == $past(wd_reg) + 1'b1;
   endproperty
   a_count_step: assert property (p_count_step) // RL7
      else $error("watchdog did not advance");

   property p_overflow;
      @(posedge sys_clk) disable iff (rst)
      (wd_step && wd_reg == WD_LAST && !clear_hit) |=> ##1 internal_reset;
   endproperty
   a_overflow: assert property (p_overflow) // RL8
      else $error("overflow did not reset");

   property p_disabled;
      @(posedge sys_clk) disable iff (rst)
      (key_reg == WRU_KEY_OFF && !clear_hit && !blk_rst)
         |=> wd_reg == $past(wd_reg);
   endproperty
   a_disabled: assert property (p_disabled) // RL14
      else $error("disabled watchdog moved");

   property p_clear;
      @(posedge sys_clk) disable iff (rst)
      (wr_clear && reg_req.wdata == WRU_CLR_FIRST && !blk_rst)
         ##1 (wr_clear && reg_req.wdata == WRU_CLR_SECOND && !blk_rst)
         |=> wd_reg == '0;
   endproperty
   a_clear: assert property (p_clear) // RL11
      else $error("refresh sequence did not clear");

   property p_cancel;
      @(posedge sys_clk) disable iff (rst)
      (wr_clear && reg_req.wdata != WRU_CLR_FIRST)
         |=> clr_reg == WRU_IDLE;
   endproperty
   a_cancel: assert property (p_cancel) // RL18
      else $error("wrong value left sequence armed");

   property p_tick_rate;
      @(posedge sys_clk) disable iff (rst)
      mc_tick |-> ##12 mc_tick;
   endproperty
   a_tick_rate: assert property (p_tick_rate) // RL16
      else $error("machine cycle not twelve clocks");

   property p_clear_wo;
      @(posedge sys_clk) disable iff (rst)
      (reg_req.rd && reg_req.addr == WRU_CLEAR_OFS) |=> reg_rdata == 8'h00;
   endproperty
   a_clear_wo: assert property (p_clear_wo) // RL13
      else $error("clear register readable");

   property p_rdata_idle;
      @(posedge sys_clk) disable iff (rst)
      !reg_req.rd |=> reg_rdata == WRU_RDATA_NONE;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) // RL13
      else $error("read data stood without a read");

   property p_key_write;
      @(posedge sys_clk) disable iff (rst)
      (wr_key && !blk_rst) |=> key_reg == $past(reg_req.wdata);
   endproperty
   a_key_write: assert property (p_key_write) // RL14
      else $error("key write not taken");

   c_overflow: cover property (@(posedge sys_clk) disable iff (rst) wd_over);
   c_refresh: cover property (@(posedge sys_clk) disable iff (rst)
      clear_hit);
   c_lv_release: cover property (@(posedge sys_clk) disable iff (rst)
      $fell(lv_s));
   c_key_off: cover property (@(posedge sys_clk) disable iff (rst)
      !wd_en);

endmodule

`default_nettype wire

// >>> wru_partner.sv
// Purpose: far side model, external reset circuit and supply monitor
// Assumes: tasks are called by the bench right after a rising edge
// Notes: pin idles high like a pulled-up reset line

`timescale 1ns/1ps
`default_nettype none

module wru_partner (
   // clock
   input wire logic sys_clk,
   // reset causes
   output logic ext_reset_n,
   output logic supply_low
);
   initial begin
      ext_reset_n = 1'b1;
      supply_low = 1'b0;
   end

   // a pin pulse shorter than 24 clocks is never sent
   task automatic ext_hold(input int n);
      ext_reset_n <= 1'b0;
      repeat ((n < 24) ? 24 : n) @(posedge sys_clk);
      ext_reset_n <= 1'b1;
   endtask

   task automatic supply_dip(input int n);
      supply_low <= 1'b1;
      repeat (n) @(posedge sys_clk);
      supply_low <= 1'b0;
   endtask
endmodule

`default_nettype wire

// >>> wru_top_tb.sv
// Purpose: self-checking bench of the watchdog and reset unit
// Assumes: shortened counts, read data one cycle after the strobe
// Notes: reads are checked from a queue by a separate watcher

`timescale 1ns/1ps
`default_nettype none

module wru_top_tb;
   import wru_pkg::*;
   localparam int LIM = 64;
   localparam int PUL = 30;
   localparam int HLD = 20;
   // tick phase after a clear is not fixed, hence the window
   localparam int OVF_MIN = LIM * WRU_MC_CLOCKS - 18;
   localparam int OVF_MAX = LIM * WRU_MC_CLOCKS + 8;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   wru_req_s reg_req = '0;
   logic [7:0] reg_rdata;
   logic internal_reset;
   logic watchdog_enabled;
   logic ext_reset_n;
   logic supply_low;
   logic rd_seen = 1'b0;
   logic ir_d = 1'b1;
   logic [7:0] k;
   logic [7:0] exp_q[$];
   int fails = 0;
   int n_compared = 0;
   int rises = 0;
   int r0;
   int n;

   always #50 sys_clk = ~sys_clk;

   wru_top #(.WD_LIMIT(LIM), .WD_PULSE_CYCLES(PUL), .LV_HOLD_CYCLES(HLD))
   wru_top_inst (.sys_clk(sys_clk), .rst(rst), .ext_reset_n(ext_reset_n),
      .supply_low(supply_low), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .internal_reset(internal_reset),
      .watchdog_enabled(watchdog_enabled));

   wru_partner wru_partner_inst (.sys_clk(sys_clk),
      .ext_reset_n(ext_reset_n), .supply_low(supply_low));

   // -------------------------------------------
   // checking and ending
   // -------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %0h want %0h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic results();
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      if (rd_seen) begin
         if (exp_q.size() == 0)
            check(1, 0, "stray read");
         else
            check(reg_rdata, exp_q.pop_front(), "read data");
      end
      rd_seen <= reg_req.rd;
   end

   // counts every start of an internal reset
   always @(posedge sys_clk) begin
      if (internal_reset === 1'b1 && ir_d === 1'b0)
         rises++;
      ir_d <= internal_reset;
   end

   // -------------------------------------------
   // drivers
   // -------------------------------------------
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
      reg_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge sys_clk);
      reg_req <= '0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask

   task automatic refresh();
      wr(WRU_CLEAR_OFS, WRU_CLR_FIRST);
      wr(WRU_CLEAR_OFS, WRU_CLR_SECOND);
   endtask

   task automatic wait_ir(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge sys_clk);
         cnt++;
      end while (internal_reset !== lvl && cnt < lim);
      if (internal_reset !== lvl) begin
         fails++;
         $display("wrong value at %0t: reset wait ran out", $time);
         results();
      end
   endtask

   // -------------------------------------------
   // scenarios
   // -------------------------------------------
   initial begin
      n = $urandom(33);
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      wait_ir(1'b0, 200, n);
      wr(WRU_STATUS_OFS, 8'h1c);
      rd(WRU_STATUS_OFS, 8'h01);
      rd(WRU_KEY_OFS, WRU_KEY_RST);
      rd(WRU_CLEAR_OFS, WRU_RDATA_NONE);
      rd(8'h10, WRU_RDATA_NONE);
      wr(WRU_CLEAR_OFS, WRU_CLR_FIRST);
      wr(WRU_CLEAR_OFS, WRU_CLR_FIRST);
      rd(WRU_STATUS_OFS, 8'h03);
      wr(WRU_CLEAR_OFS, 8'h00);
      rd(WRU_STATUS_OFS, 8'h01);
      refresh();
      rd(WRU_STATUS_OFS, 8'h01);
      for (int i = 0; i < 5; i++) begin
         k = (i == 0) ? WRU_KEY_OFF : 8'($urandom_range(0, 255));
         wr(WRU_KEY_OFS, k);
         // enable output lags the key by one registered stage
         @(negedge sys_clk);
         check(watchdog_enabled, k != WRU_KEY_OFF, "enable");
         @(posedge sys_clk);
         rd(WRU_KEY_OFS, k);
      end
      wr(WRU_KEY_OFS, 8'hf0);
      refresh();
      r0 = rises;
      repeat (3) begin
         repeat (500) @(posedge sys_clk);
         refresh();
      end
      check(rises, r0, "reset while refreshed");
      wr(WRU_KEY_OFS, WRU_KEY_OFF);
      repeat (1000) @(posedge sys_clk);
      check(rises, r0, "reset while stopped");
      refresh();
      wr(WRU_KEY_OFS, 8'hf0);
      refresh();
      wait_ir(1'b1, 1000, n);
      check(n >= OVF_MIN && n <= OVF_MAX, 1, "overflow time");
      wait_ir(1'b0, 100, n);
      check(n, PUL, "pulse width");
      rd(WRU_STATUS_OFS, 8'h05);
      wr(WRU_STATUS_OFS, 8'h1c);
      wr(WRU_KEY_OFS, WRU_KEY_OFF);
      wru_partner_inst.ext_hold(24);
      check(internal_reset, 1, "pin reset");
      wait_ir(1'b0, 8, n);
      check(watchdog_enabled, 1, "enabled again");
      rd(WRU_KEY_OFS, WRU_KEY_RST);
      rd(WRU_STATUS_OFS, 8'h11);
      wr(WRU_STATUS_OFS, 8'h1c);
      wru_partner_inst.supply_dip(10);
      check(internal_reset, 1, "supply reset");
      wait_ir(1'b0, 40, n);
      check(n >= HLD && n <= HLD + 6, 1, "supply hold");
      rd(WRU_STATUS_OFS, 8'h09);
      results();
   end
endmodule

`default_nettype wire
